// ### hw/dmc_top.sv
// dmc_top: debug mode selection, stop control, event recording and debug interrupt
// assumes core-side inputs are on clk; the link pins are handled by dmc_link_shift
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - enable each event; record all in status
// - registers reachable from port and link
// - internal mode raises debug interrupt when allowed
// - internal mode only with its enable set
// - external mode records then enters stop
// - external stop holds interrupts disabled
// - translation checks stay on while debugging
// - external mode only with its enable set
// - both modes: stop wins, interrupt stays pending
// - wait mode stops; enabled interrupt ends stop
// - wait mode needs both enable bits
// - interrupt clears wait bit; return restores it
// - wait plus external behaves as external
// - wait plus internal: allowed interrupt, else stop
// - trace mode when no other mode enabled
// - trace mode only records and traces
// - link halt raises unconditional event
module dmc_top (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic [dmc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [dmc_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [dmc_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic [dmc_pkg::EVT_NUM-1:0] evt_raw,
  input  wire logic                        intr_taken,
  input  wire logic                        rfi_exec,
  input  wire logic                        intr_req,
  input  wire logic                        dbg_int_ack,
  input  wire logic                        link_clk,
  input  wire logic                        link_sel,
  input  wire logic                        link_tdi,
  output logic                             link_tdo,
  output logic                             core_stop,
  output logic                             core_step,
  output logic                             intr_block,
  output logic                             dbg_int_req,
  output logic                             xlate_check,
  output logic                             trace_vld,
  output logic      [dmc_pkg::STAT_W-1:0]  trace_evt,
  output logic                             irq
);
  // register state
  logic [dmc_pkg::CTRL_W-1:0]  ctrl_ff, nxt_ctrl;
  logic [dmc_pkg::STAT_W-1:0]  stat_ff, nxt_stat;
  logic [dmc_pkg::STAT_W-1:0]  mask_ff, nxt_mask;
  logic [dmc_pkg::MSR_W-1:0]   msr_ff, nxt_msr;
  logic                        save_dwe_ff, nxt_save_dwe;
  logic                        jwe_ff, nxt_jwe;
  logic [dmc_pkg::DATA_W-1:0]  rdata_ff, nxt_rdata;
  // control state
  dmc_pkg::dmc_run_e           run_ff, nxt_run;
  logic                        pend_ff, nxt_pend;
  logic                        step_ff, nxt_step;
  logic                        idis_ff, nxt_idis;
  logic                        dreq_ff, nxt_dreq;
  logic                        xlate_ff;
  logic                        stop_ff, nxt_stop;
  logic                        tvld_ff, nxt_tvld;
  logic [dmc_pkg::STAT_W-1:0]  tevt_ff, nxt_tevt;
  logic                        irq_ff, nxt_irq;
  logic                        lnk_load_ff, nxt_lnk_load;
  logic [dmc_pkg::LNK_DW-1:0]  lnk_data_ff, nxt_lnk_data;
  // link command
  logic                        cmd_vld;
  logic [dmc_pkg::LNK_W-1:0]   cmd_word;
  logic [3:0]                  cmd_op;
  logic [dmc_pkg::ADDR_W-1:0]  cmd_addr;
  logic [dmc_pkg::LNK_DW-1:0]  cmd_data;
  // decoded modes and events
  logic                        int_mode, ext_mode, wait_mode, trc_mode;
  logic [dmc_pkg::STAT_W-1:0]  evt_hit;
  logic                        any_evt;
  logic                        lnk_wr, lnk_rd;
  logic [dmc_pkg::ADDR_W-1:0]  w_addr;
  logic [dmc_pkg::DATA_W-1:0]  w_data;
  logic                        w_en;
  logic [dmc_pkg::DATA_W-1:0]  rd_val;
  logic [dmc_pkg::ADDR_W-1:0]  rd_addr;
  logic [dmc_pkg::STATE_W-1:0] state_val;

  dmc_link_shift u_link (
    .clk       (clk),
    .rst_b     (rst_b),
    .link_clk  (link_clk),
    .link_sel  (link_sel),
    .link_tdi  (link_tdi),
    .load      (lnk_load_ff),
    .load_data (lnk_data_ff),
    .cmd_vld   (cmd_vld),
    .cmd_word  (cmd_word),
    .tdo       (link_tdo)
  );

  assign cmd_op   = cmd_word[dmc_pkg::LNK_W-1 -: 4];
  assign cmd_addr = {2'b00, cmd_word[dmc_pkg::LNK_DW +: 4], 2'b00};
  assign cmd_data = cmd_word[dmc_pkg::LNK_DW-1:0];
  assign lnk_wr   = cmd_vld & (cmd_op == dmc_pkg::CMD_WRITE);
  assign lnk_rd   = cmd_vld & (cmd_op == dmc_pkg::CMD_READ);

  // the port wins a write collision; a link write in that cycle is lost
  assign w_en   = reg_wr | lnk_wr;
  assign w_addr = reg_wr ? reg_addr : cmd_addr;
  assign w_data = reg_wr ? reg_wdata : {{(dmc_pkg::DATA_W-dmc_pkg::LNK_DW){1'b0}}, cmd_data};

  assign int_mode  = ctrl_ff[dmc_pkg::CTRL_IDM];
  assign ext_mode  = ctrl_ff[dmc_pkg::CTRL_EDM];
  assign wait_mode = msr_ff[dmc_pkg::MSR_DWE] & jwe_ff;
  assign trc_mode  = ~int_mode & ~ext_mode & ~wait_mode;

  // each comparator event needs its own enable; the link halt needs none
  assign evt_hit[dmc_pkg::EVT_NUM-1:0] =
    evt_raw & ctrl_ff[dmc_pkg::CTRL_EN_LO +: dmc_pkg::EVT_NUM];
  assign evt_hit[dmc_pkg::EVT_UNC] = cmd_vld & (cmd_op == dmc_pkg::CMD_HALT);
  assign any_evt = |evt_hit;

  always_comb begin
    state_val                   = '0;
    state_val[dmc_pkg::ST_STOP] = run_ff != dmc_pkg::RUN_S;
    state_val[dmc_pkg::ST_IDIS] = idis_ff;
    state_val[dmc_pkg::ST_EXT]  = ext_mode;
    state_val[dmc_pkg::ST_INT]  = int_mode;
    state_val[dmc_pkg::ST_WAIT] = wait_mode;
    state_val[dmc_pkg::ST_TRC]  = trc_mode;
    state_val[dmc_pkg::ST_JWE]  = jwe_ff;
    state_val[dmc_pkg::ST_PEND] = pend_ff;
  end

  // shared read mux for the port and the link
  assign rd_addr = reg_rd ? reg_addr : cmd_addr;
  always_comb begin
    rd_val = '0;
    unique case (rd_addr)
      dmc_pkg::ADDR_CTRL:   rd_val[dmc_pkg::CTRL_W-1:0]  = ctrl_ff;
      dmc_pkg::ADDR_STATUS: rd_val[dmc_pkg::STAT_W-1:0]  = stat_ff;
      dmc_pkg::ADDR_MASK:   rd_val[dmc_pkg::STAT_W-1:0]  = mask_ff;
      dmc_pkg::ADDR_MSR:    rd_val[dmc_pkg::MSR_W-1:0]   = msr_ff;
      dmc_pkg::ADDR_STATE:  rd_val[dmc_pkg::STATE_W-1:0] = state_val;
      default:              rd_val = '0;
    endcase
  end

  // register file
  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_mask     = mask_ff;
    nxt_msr      = msr_ff;
    nxt_save_dwe = save_dwe_ff;
    nxt_jwe      = jwe_ff;
    nxt_stat     = stat_ff;
    nxt_rdata    = '0;
    nxt_lnk_load = 1'b0;
    nxt_lnk_data = lnk_data_ff;
    if (w_en) begin
      unique case (w_addr)
        dmc_pkg::ADDR_CTRL:   nxt_ctrl = w_data[dmc_pkg::CTRL_W-1:0];
        dmc_pkg::ADDR_STATUS: nxt_stat = stat_ff & ~w_data[dmc_pkg::STAT_W-1:0];
        dmc_pkg::ADDR_MASK:   nxt_mask = w_data[dmc_pkg::STAT_W-1:0];
        dmc_pkg::ADDR_MSR:    nxt_msr  = w_data[dmc_pkg::MSR_W-1:0];
        default:              nxt_ctrl = ctrl_ff;
      endcase
    end
    // events are recorded in every mode, and a new event beats a clear
    nxt_stat = nxt_stat | evt_hit;
    if (intr_taken) begin
      nxt_save_dwe               = msr_ff[dmc_pkg::MSR_DWE];
      nxt_msr[dmc_pkg::MSR_DWE]  = 1'b0;
    end else if (rfi_exec) begin
      nxt_msr[dmc_pkg::MSR_DWE]  = save_dwe_ff;
    end
    if (cmd_vld && (cmd_op == dmc_pkg::CMD_WAITEN)) begin
      nxt_jwe = cmd_data[0];
    end
    if (reg_rd) begin
      nxt_rdata = rd_val;
    end
    if (lnk_rd && !reg_rd) begin
      nxt_lnk_load = 1'b1;
      nxt_lnk_data = rd_val[dmc_pkg::LNK_DW-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff     <= '0;
      stat_ff     <= '0;
      mask_ff     <= '0;
      msr_ff      <= '0;
      save_dwe_ff <= 1'b0;
      jwe_ff      <= 1'b0;
      rdata_ff    <= '0;
      lnk_load_ff <= 1'b0;
      lnk_data_ff <= '0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      stat_ff     <= nxt_stat;
      mask_ff     <= nxt_mask;
      msr_ff      <= nxt_msr;
      save_dwe_ff <= nxt_save_dwe;
      jwe_ff      <= nxt_jwe;
      rdata_ff    <= nxt_rdata;
      lnk_load_ff <= nxt_lnk_load;
      lnk_data_ff <= nxt_lnk_data;
    end
  end

  // mode response and stop control
  always_comb begin
    nxt_run  = run_ff;
    nxt_pend = pend_ff;
    nxt_step = 1'b0;
    if (any_evt && int_mode) begin
      nxt_pend = 1'b1;
    end
    if (dbg_int_ack) begin
      nxt_pend = 1'b0;
    end
    unique case (run_ff)
      dmc_pkg::RUN_S: begin
        if (any_evt && ext_mode) begin
          nxt_run = dmc_pkg::STOP_S;
        end else if (any_evt && wait_mode
                     && !(int_mode && msr_ff[dmc_pkg::MSR_DE])) begin
          nxt_run = dmc_pkg::STOP_S;
        end
      end
      dmc_pkg::STOP_S: begin
        if (cmd_vld && (cmd_op == dmc_pkg::CMD_RESUME)) begin
          nxt_run = dmc_pkg::RUN_S;
        end else if (cmd_vld && (cmd_op == dmc_pkg::CMD_STEP)) begin
          nxt_run  = dmc_pkg::STEP_S;
          nxt_step = 1'b1;
        end else if (intr_req && wait_mode && !ext_mode) begin
          nxt_run = dmc_pkg::RUN_S;
        end
      end
      dmc_pkg::STEP_S: begin
        // the core runs until evt_raw[EVT_ICMP] is seen, then stops again
        if (evt_raw[dmc_pkg::EVT_ICMP]) begin
          nxt_run = dmc_pkg::STOP_S;
        end
      end
      default: nxt_run = dmc_pkg::RUN_S;
    endcase
  end

  // outputs to the core, trace and interrupt line
  always_comb begin
    // external stop masks all interrupts, also in wait mode
    nxt_idis = (nxt_run != dmc_pkg::RUN_S) && ext_mode;
    // a debug interrupt stays pending but is not issued while stopped externally
    nxt_dreq = nxt_pend && msr_ff[dmc_pkg::MSR_DE] && !nxt_idis;
    nxt_tvld = any_evt;
    nxt_tevt = evt_hit;
    nxt_irq  = |(nxt_stat & mask_ff);
    // registered copy so the halt line leaves a flip-flop directly
    nxt_stop = nxt_run == dmc_pkg::STOP_S;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_ff   <= dmc_pkg::RUN_S;
      pend_ff  <= 1'b0;
      step_ff  <= 1'b0;
      idis_ff  <= 1'b0;
      dreq_ff  <= 1'b0;
      xlate_ff <= 1'b0;
      stop_ff  <= 1'b0;
      tvld_ff  <= 1'b0;
      tevt_ff  <= '0;
      irq_ff   <= 1'b0;
    end else begin
      run_ff   <= nxt_run;
      pend_ff  <= nxt_pend;
      step_ff  <= nxt_step;
      idis_ff  <= nxt_idis;
      dreq_ff  <= nxt_dreq;
      xlate_ff <= 1'b1;
      stop_ff  <= nxt_stop;
      tvld_ff  <= nxt_tvld;
      tevt_ff  <= nxt_tevt;
      irq_ff   <= nxt_irq;
    end
  end

  assign reg_rdata   = rdata_ff;
  assign core_stop   = stop_ff;
  assign core_step   = step_ff;
  assign intr_block  = idis_ff;
  assign dbg_int_req = dreq_ff;
  assign xlate_check = xlate_ff;
  assign trace_vld   = tvld_ff;
  assign trace_evt   = tevt_ff;
  assign irq         = irq_ff;
endmodule
`default_nettype wire

// ### hw/dmc_pkg.sv
// dmc_pkg: constants shared by the debug mode controller and its link shifter
// assumes a 50 MHz core clock and a link clock sampled by that clock
package dmc_pkg;
  // register byte addresses on the plain register port
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_MSR    = 8'h0C;
  localparam logic [7:0] ADDR_STATE  = 8'h10;
  localparam int         ADDR_W      = 8;
  localparam int         DATA_W      = 32;

  // debug_control_first layout
  localparam int CTRL_IDM   = 0;
  localparam int CTRL_EDM   = 1;
  localparam int CTRL_EN_LO = 2;
  localparam int CTRL_W     = 10;

  // event numbering; status and mask share this layout
  localparam int EVT_NUM  = 8;
  localparam int EVT_ICMP = 6;
  localparam int EVT_UNC  = 8;
  localparam int STAT_W   = 9;

  // machine_state_reg layout
  localparam int MSR_DE  = 0;
  localparam int MSR_DWE = 1;
  localparam int MSR_W   = 2;

  // debug_state read-only layout
  localparam int ST_STOP = 0;
  localparam int ST_IDIS = 1;
  localparam int ST_EXT  = 2;
  localparam int ST_INT  = 3;
  localparam int ST_WAIT = 4;
  localparam int ST_TRC  = 5;
  localparam int ST_JWE  = 6;
  localparam int ST_PEND = 7;
  localparam int STATE_W = 8;

  // link frame: command, register index, data, sent msb first
  localparam int LNK_W     = 24;
  localparam int LNK_DW    = 16;
  localparam int LNK_CNT_W = 5;
  localparam logic [3:0] CMD_WRITE = 4'h1;
  localparam logic [3:0] CMD_READ  = 4'h2;
  localparam logic [3:0] CMD_HALT  = 4'h3;
  localparam logic [3:0] CMD_RESUME = 4'h4;
  localparam logic [3:0] CMD_STEP  = 4'h5;
  localparam logic [3:0] CMD_WAITEN = 4'h6;

  typedef enum logic [1:0] {
    RUN_S  = 2'b00,
    STOP_S = 2'b01,
    STEP_S = 2'b10
  } dmc_run_e;
endpackage

// ### hw/dmc_link_shift.sv
// dmc_link_shift: serial command receiver and read-back shifter of the debug link
// assumes link_clk, link_sel and link_tdi come from pins, asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module dmc_link_shift (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       link_clk,
  input  wire logic                       link_sel,
  input  wire logic                       link_tdi,
  input  wire logic                       load,
  input  wire logic [dmc_pkg::LNK_DW-1:0] load_data,
  output logic                            cmd_vld,
  output logic [dmc_pkg::LNK_W-1:0]       cmd_word,
  output logic                            tdo
);
  logic [2:0]                      s1_ff, s2_ff;
  logic                            clk_d_ff, sel_d_ff;
  logic [dmc_pkg::LNK_W-1:0]       sh_ff, nxt_sh;
  logic [dmc_pkg::LNK_CNT_W-1:0]   cnt_ff, nxt_cnt;
  logic [dmc_pkg::LNK_DW-1:0]      rd_ff, nxt_rd;
  logic                            vld_ff, nxt_vld;
  logic [dmc_pkg::LNK_W-1:0]       word_ff, nxt_word;
  logic                            tdo_ff, nxt_tdo;
  logic                            rise, fall, sel_end;

  assign rise    = s2_ff[0] & ~clk_d_ff & s2_ff[1];
  assign fall    = ~s2_ff[0] & clk_d_ff & s2_ff[1];
  assign sel_end = sel_d_ff & ~s2_ff[1];

  always_comb begin
    nxt_sh   = sh_ff;
    nxt_cnt  = cnt_ff;
    nxt_rd   = rd_ff;
    nxt_vld  = 1'b0;
    nxt_word = word_ff;
    nxt_tdo  = tdo_ff;
    if (rise) begin
      nxt_sh = {sh_ff[dmc_pkg::LNK_W-2:0], s2_ff[2]};
      if (cnt_ff != dmc_pkg::LNK_CNT_W'(dmc_pkg::LNK_W)) begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
    if (fall) begin
      nxt_tdo = rd_ff[dmc_pkg::LNK_DW-1];
      nxt_rd  = {rd_ff[dmc_pkg::LNK_DW-2:0], 1'b0};
    end
    // a frame shorter than 24 bits is dropped whole; a longer one keeps its last 24 bits
    if (sel_end) begin
      nxt_cnt = '0;
      if (cnt_ff == dmc_pkg::LNK_CNT_W'(dmc_pkg::LNK_W)) begin
        nxt_vld  = 1'b1;
        nxt_word = sh_ff;
      end
    end
    if (load) begin
      nxt_rd = load_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      clk_d_ff <= 1'b0;
      sel_d_ff <= 1'b0;
      sh_ff    <= '0;
      cnt_ff   <= '0;
      rd_ff    <= '0;
      vld_ff   <= 1'b0;
      word_ff  <= '0;
      tdo_ff   <= 1'b0;
    end else begin
      s1_ff    <= {link_tdi, link_sel, link_clk};
      s2_ff    <= s1_ff;
      clk_d_ff <= s2_ff[0];
      sel_d_ff <= s2_ff[1];
      sh_ff    <= nxt_sh;
      cnt_ff   <= nxt_cnt;
      rd_ff    <= nxt_rd;
      vld_ff   <= nxt_vld;
      word_ff  <= nxt_word;
      tdo_ff   <= nxt_tdo;
    end
  end

  assign cmd_vld  = vld_ff;
  assign cmd_word = word_ff;
  assign tdo      = tdo_ff;
endmodule
`default_nettype wire

// ### bench/dmc_props.sv
// dmc_props: port-level checks of the debug mode controller
// assumes one clock domain on clk with asynchronous active-low rst_b
`timescale 1ns/1ps
`default_nettype none
module dmc_props (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0]  evt_raw,
  input wire logic        intr_req,
  input wire logic        link_sel,
  input wire logic        core_stop,
  input wire logic        core_step,
  input wire logic        intr_block,
  input wire logic        dbg_int_req,
  input wire logic        xlate_check,
  input wire logic        trace_vld,
  input wire logic [8:0]  trace_evt,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // cycles since the link frame select was last high, saturating
  logic [4:0] sel_age_ff;
  logic [4:0] nxt_sel_age;
  always_comb begin
    nxt_sel_age = sel_age_ff;
    if (link_sel) nxt_sel_age = 5'h00;
    else if (sel_age_ff != 5'h1F) nxt_sel_age = sel_age_ff + 5'h01;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sel_age_ff <= 5'h1F;
    else sel_age_ff <= nxt_sel_age;
  end
  sequence s_wait_stop;
    core_stop && !intr_block && intr_req;
  endsequence
  sequence s_left_stop;
    ##[1:3] !core_stop;
  endsequence
  a_xlate_on: assert property ($past(rst_b) |-> xlate_check)
    else $error("translation checks off");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_step_pulse: assert property (core_step |=> !core_step)
    else $error("step pulse too long");
  a_block_stop: assert property (intr_block |-> core_stop)
    else $error("interrupts blocked while running");
  a_int_vs_stop: assert property (dbg_int_req |-> !intr_block)
    else $error("debug interrupt during external stop");
  a_trace_cause: assert property (trace_vld && !trace_evt[8] |-> $past(evt_raw) != 8'h00)
    else $error("trace without event");
  a_stop_cause: assert property ($rose(core_stop) |-> trace_vld || $past(evt_raw[6]))
    else $error("stop without recorded event");
  a_stop_exit: assert property ($fell(core_stop) |-> $past(intr_req) || sel_age_ff < 5'd12)
    else $error("stop left without cause");
  a_wait_exit: assert property (s_wait_stop |-> s_left_stop)
    else $error("wait stop kept despite interrupt");
  a_irq_cause: assert property ($rose(irq) |-> trace_vld || $past(reg_wr) || $past(reg_wr, 2))
    else $error("irq without cause");
endmodule
bind dmc_top dmc_props u_props (
  .clk, .rst_b, .reg_wr, .reg_rd, .reg_rdata, .evt_raw, .intr_req, .link_sel,
  .core_stop, .core_step, .intr_block, .dbg_int_req, .xlate_check, .trace_vld,
  .trace_evt, .irq
);
`default_nettype wire

// ### bench/dmc_link_tool.sv
// dmc_link_tool: debug tool model driving serial link frames
// assumes the bench calls frame; link clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module dmc_link_tool (
  output logic      link_clk,
  output logic      link_sel,
  output logic      link_tdi,
  input wire logic  link_tdo
);
  logic [23:0] shot_q;
  initial begin
    link_clk = 1'b0;
    link_sel = 1'b0;
    link_tdi = 1'b1;
  end
  // 160 ns link period, msb first, read data caught before each fall
  task automatic frame(input logic [23:0] w);
    #37 link_sel = 1'b1;
    for (int i = 23; i >= 0; i--) begin
      link_tdi = w[i];
      #80 link_clk = 1'b1;
      #80 shot_q[i] = link_tdo;
      link_clk = 1'b0;
    end
    #80 link_sel = 1'b0;
    link_tdi = ~link_tdi;
  endtask
endmodule
`default_nettype wire

// ### bench/dmc_top_test.sv
// dmc_top_test: self-checking bench of dmc_top with the link tool model
// assumes dmc_pkg, dmc_top, dmc_link_tool and dmc_props are compiled first
`timescale 1ns/1ps
`default_nettype none
module dmc_top_test;
  logic        clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0]  evt_raw;
  logic [2:0]  pz;
  logic        intr_req;
  wire         link_clk;
  wire         link_sel;
  wire         link_tdi;
  logic        link_tdo;
  logic        core_stop;
  logic        core_step;
  logic        intr_block;
  logic        dbg_int_req;
  logic        xlate_check;
  logic        trace_vld;
  logic [8:0]  trace_evt;
  logic        irq;
  logic [31:0] v;
  int          n_mismatch;
  int          cmp_count;
  int          cyc;
  dmc_top u_dut (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .evt_raw,
    .intr_taken(pz[0]), .rfi_exec(pz[1]), .intr_req, .dbg_int_ack(pz[2]),
    .link_clk, .link_sel, .link_tdi, .link_tdo, .core_stop, .core_step,
    .intr_block, .dbg_int_req, .xlate_check, .trace_vld, .trace_evt, .irq
  );
  dmc_link_tool u_tool (.link_clk, .link_sel, .link_tdi, .link_tdo);
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // one-cycle event pulse; returns just after the edge that records it
  task automatic ev(input int b);
    @(posedge clk) evt_raw <= 8'h01 << b;
    @(posedge clk) evt_raw <= 8'h00;
    #1;
  endtask
  task automatic pu(input logic [2:0] m);
    @(posedge clk) pz <= m;
    @(posedge clk) pz <= 3'h0;
    #1;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic lk(input logic [3:0] c, input logic [19:0] d);
    u_tool.frame({c, d});
    cy(12);
  endtask
  task automatic t_regs;
    rd(8'h00, 32'h0);
    wr(8'h10, 32'hFF);
    rd(8'h10, 32'h1 << dmc_pkg::ST_TRC);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h3FF);
    wr(8'h14, 32'hFF);
    rd(8'h14, 32'h0);
    chk(xlate_check, 32'h1);
  endtask
  task automatic t_trace;
    wr(8'h00, 32'h3FC);
    for (int b = 0; b < 8; b++) begin
      ev(b);
      chk({trace_vld, core_stop, dbg_int_req}, 32'h4);
      chk(trace_evt, 32'h1 << b);
    end
    wr(8'h04, 32'h0F);
    rd(8'h04, 32'hF0);
    wr(8'h04, 32'h1FF);
    wr(8'h00, 32'h3F8);
    ev(0);
    chk(trace_vld, 32'h0);
    rd(8'h04, 32'h0);
  endtask
  task automatic t_int;
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'h3FC);
    ev(0);
    cy(2);
    chk(dbg_int_req, 32'h0);
    wr(8'h00, 32'h3FD);
    ev(0);
    cy(2);
    chk({core_stop, dbg_int_req}, 32'h1);
    pu(3'h4);
    cy(2);
    chk(dbg_int_req, 32'h0);
  endtask
  task automatic t_ext;
    wr(8'h00, 32'h3FF);
    ev(1);
    chk({core_stop, intr_block}, 32'h3);
    @(posedge clk) intr_req <= 1'b1;
    cy(4);
    chk({core_stop, dbg_int_req}, 32'h2);
    @(posedge clk) intr_req <= 1'b0;
    rd(8'h10, 32'h8F);
    lk(dmc_pkg::CMD_RESUME, 20'h0);
    chk({core_stop, intr_block, dbg_int_req}, 32'h1);
    pu(3'h4);
    wr(8'h00, 32'h3FE);
    ev(1);
    chk(core_stop, 32'h1);
    lk(dmc_pkg::CMD_RESUME, 20'h0);
  endtask
  task automatic t_wait;
    wr(8'h00, 32'h3FC);
    wr(8'h0C, 32'h2);
    ev(2);
    chk(core_stop, 32'h0);
    lk(dmc_pkg::CMD_WAITEN, 20'h1);
    ev(2);
    chk({core_stop, intr_block}, 32'h2);
    u_tool.frame({dmc_pkg::CMD_STEP, 20'h0});
    v = 32'h0;
    repeat (14) begin
      @(posedge clk);
      #1 v = v + core_step;
    end
    chk({v[3:0], core_stop}, 32'h2);
    ev(6);
    chk(core_stop, 32'h1);
    @(posedge clk) intr_req <= 1'b1;
    cy(4);
    chk(core_stop, 32'h0);
    @(posedge clk) intr_req <= 1'b0;
    pu(3'h1);
    rd(8'h0C, 32'h0);
    pu(3'h2);
    rd(8'h0C, 32'h2);
  endtask
  task automatic t_mix;
    wr(8'h0C, 32'h3);
    wr(8'h00, 32'h3FD);
    ev(3);
    cy(2);
    chk({core_stop, dbg_int_req}, 32'h1);
    pu(3'h4);
    wr(8'h0C, 32'h2);
    ev(3);
    chk(core_stop, 32'h1);
    lk(dmc_pkg::CMD_RESUME, 20'h0);
    wr(8'h00, 32'h3FE);
    ev(4);
    @(posedge clk) intr_req <= 1'b1;
    cy(4);
    chk({core_stop, intr_block}, 32'h3);
    @(posedge clk) intr_req <= 1'b0;
    lk(dmc_pkg::CMD_RESUME, 20'h0);
  endtask
  task automatic t_irq;
    wr(8'h00, 32'h3FC);
    wr(8'h0C, 32'h0);
    wr(8'h04, 32'h1FF);
    wr(8'h08, 32'h08);
    ev(4);
    chk({core_stop, irq}, 32'h0);
    ev(3);
    chk(irq, 32'h1);
    wr(8'h04, 32'h08);
    cy(2);
    chk(irq, 32'h0);
    wr(8'h08, 32'h10);
    cy(2);
    chk(irq, 32'h1);
  endtask
  task automatic t_link;
    wr(8'h04, 32'h1FF);
    lk(dmc_pkg::CMD_WRITE, 20'h003FC);
    rd(8'h00, 32'h3FC);
    lk(dmc_pkg::CMD_HALT, 20'h0);
    rd(8'h04, 32'h100);
    lk(dmc_pkg::CMD_READ, 20'h10000);
    lk(4'h0, 20'h0);
    v = 32'((u_tool.shot_q[22:7] === 16'h0100) || (u_tool.shot_q[23:8] === 16'h0100));
    chk(v, 32'h1);
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    evt_raw = 8'h00;
    pz = 3'h0;
    intr_req = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_trace();
    t_int();
    t_ext();
    t_wait();
    t_mix();
    t_irq();
    t_link();
    close_out();
  end
endmodule
`default_nettype wire
